// >>> rtl/tpg_map.vh
`ifndef TPG_MAP_VH
`define TPG_MAP_VH
// ==========================================================
// Widths
`define TPG_A_WIDTH        5
`define TPG_B_WIDTH        8
// ==========================================================
// Field positions
`define TPG_A_OPEN_DRAIN_BIT  4
`define TPG_B_UPPER_LSB       4
`define TPG_B_UPPER_MSB       7
`define TPG_PULLUP_CTRL_BIT   7
`define TPG_CHANGE_FLAG_BIT   0
// ==========================================================
// Reset values
`define TPG_A_DIR_RESET    5'h1F
`define TPG_A_LATCH_RESET  5'h00
`define TPG_B_DIR_RESET    8'hFF
`define TPG_B_LATCH_RESET  8'h00
`define TPG_PULLUP_N_RESET 1'h1
`endif

// >>> rtl/tpg_change_detect.v
`include "tpg_map.vh"
module tpg_change_detect (
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    // Upper pin state
    input  wire [3:0] upper_pins,
    input  wire [3:0] upper_dir,
    // Reference capture
    input  wire       capture,
    // Mismatch result
    output reg        mismatch_reg
);
    // ==========================================================
    // Reference and compare
    reg  [3:0] ref_reg;
    wire [3:0] diff;

    assign diff = (upper_pins ^ ref_reg) & upper_dir;

    always @(posedge clk) begin
        if (rst) begin
            ref_reg      <= 4'h0;
            mismatch_reg <= 1'b0;
        end else begin
            if (capture) begin
                ref_reg <= upper_pins;
            end
            // Capture cycle masks the compare
            mismatch_reg <= (|diff) & ~capture;
        end
    end
endmodule // tpg_change_detect

// >>> rtl/tpg_gpio.v
`include "tpg_map.vh"
module tpg_gpio (
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    input  wire       por,
    // Port A software side
    input  wire       port_a_data_wr,
    input  wire [4:0] port_a_data_wmask,
    input  wire [4:0] port_a_data_wdata,
    input  wire       port_a_data_rd,
    output reg  [4:0] port_a_data_rdata,
    input  wire       port_a_direction_wr,
    input  wire [4:0] port_a_direction_wdata,
    output reg  [4:0] port_a_direction,
    // Port B software side
    input  wire       port_b_data_wr,
    input  wire [7:0] port_b_data_wmask,
    input  wire [7:0] port_b_data_wdata,
    input  wire       port_b_data_rd,
    output reg  [7:0] port_b_data_rdata,
    input  wire       port_b_direction_wr,
    input  wire [7:0] port_b_direction_wdata,
    output reg  [7:0] port_b_direction,
    // Pull-up control and change flag
    input  wire       weak_pullup_wr,
    input  wire       weak_pullup_disable_n_wdata,
    output reg        weak_pullup_disable_n,
    input  wire       port_b_change_flag_clr,
    output reg        port_b_change_flag,
    input  wire       sleep_active,
    output reg        wake_request,
    // Port A pins
    input  wire [4:0] port_a_in,
    output reg  [4:0] port_a_out,
    output reg  [4:0] port_a_oe,
    output reg        timer_external_clock_in,
    // Port B pins
    input  wire [7:0] port_b_in,
    output reg  [7:0] port_b_out,
    output reg  [7:0] port_b_oe,
    output reg  [7:0] port_b_pullup_en
);
    // ==========================================================
    // Helpers
    function [7:0] rmw_merge;
        input [7:0] pins;
        input [7:0] mask;
        input [7:0] wdata;
        begin
            rmw_merge = (pins & ~mask) | (wdata & mask);
        end
    endfunction

    function [4:0] a_pad_out;
        input [4:0] latch;
        begin
            a_pad_out = latch & ~(5'h01 << `TPG_A_OPEN_DRAIN_BIT);
        end
    endfunction

    function [4:0] a_pad_oe;
        input [4:0] dir;
        input [4:0] latch;
        begin
            a_pad_oe = ~dir & ({5'h1F ^ (5'h01 << `TPG_A_OPEN_DRAIN_BIT)} | ~latch);
        end
    endfunction

    function pullup_pick;
        input wr;
        input wdata;
        input held;
        begin
            pullup_pick = wr ? wdata : held;
        end
    endfunction

    function [7:0] b_pullups;
        input       disable_n;
        input [7:0] dir;
        begin
            b_pullups = disable_n ? 8'h00 : dir;
        end
    endfunction

    // ==========================================================
    // State
    reg  [4:0] port_a_latch_reg;
    reg  [4:0] port_a_dir_reg;
    reg  [7:0] port_b_latch_reg;
    reg  [7:0] port_b_dir_reg;
    reg        pullup_n_reg;
    reg        flag_reg;
    wire       mismatch;
    wire [4:0] a_dir_next;
    wire [7:0] b_dir_next;
    wire [4:0] a_latch_next;
    wire [7:0] b_latch_next;
    wire       flag_next;
    wire [7:0] a_merge;

    // ==========================================================
    // Output next values
    wire       pullup_n_next;
    wire [4:0] a_out_next;
    wire [4:0] a_oe_next;
    wire [7:0] b_pullup_next;
    wire       wake_next;

    // ==========================================================
    // Next values
    assign a_merge = rmw_merge({3'h0, port_a_in}, {3'h0, port_a_data_wmask},
                               {3'h0, port_a_data_wdata});
    assign a_latch_next = port_a_data_wr ? a_merge[4:0]
                                         : port_a_latch_reg;
    assign b_latch_next = port_b_data_wr ?
        rmw_merge(port_b_in, port_b_data_wmask, port_b_data_wdata)
        : port_b_latch_reg;
    assign a_dir_next = port_a_direction_wr ? port_a_direction_wdata : port_a_dir_reg;
    assign b_dir_next = port_b_direction_wr ? port_b_direction_wdata : port_b_dir_reg;
    // Set wins over clear
    assign flag_next = mismatch | (flag_reg & ~port_b_change_flag_clr);
    assign pullup_n_next = pullup_pick(weak_pullup_wr, weak_pullup_disable_n_wdata,
                                       pullup_n_reg);
    // Bit 4 only pulls low
    assign a_out_next    = a_pad_out(a_latch_next);
    assign a_oe_next     = a_pad_oe(a_dir_next, a_latch_next);
    assign b_pullup_next = b_pullups(pullup_n_next, b_dir_next);
    assign wake_next     = flag_next & sleep_active;

    // ==========================================================
    // Change detector
    tpg_change_detect u_change (
        .clk          (clk),
        .rst          (rst),
        .upper_pins   (port_b_in[`TPG_B_UPPER_MSB:`TPG_B_UPPER_LSB]),
        .upper_dir    (port_b_dir_reg[`TPG_B_UPPER_MSB:`TPG_B_UPPER_LSB]),
        .capture      (port_b_data_rd | port_b_data_wr),
        .mismatch_reg (mismatch)
    );

    // ==========================================================
    // Port A output latch
    always @(posedge clk) begin
        if (rst) begin
            port_a_latch_reg <= `TPG_A_LATCH_RESET;
        end else begin
            port_a_latch_reg <= a_latch_next;
        end
    end

    // ==========================================================
    // Port A direction
    always @(posedge clk) begin
        if (rst) begin
            port_a_dir_reg <= `TPG_A_DIR_RESET;
        end else begin
            port_a_dir_reg <= a_dir_next;
        end
    end

    // ==========================================================
    // Port B output latch
    always @(posedge clk) begin
        if (rst) begin
            port_b_latch_reg <= `TPG_B_LATCH_RESET;
        end else begin
            port_b_latch_reg <= b_latch_next;
        end
    end

    // ==========================================================
    // Port B direction
    always @(posedge clk) begin
        if (rst) begin
            port_b_dir_reg <= `TPG_B_DIR_RESET;
        end else begin
            port_b_dir_reg <= b_dir_next;
        end
    end

    // ==========================================================
    // Pull-up control bit
    always @(posedge clk) begin
        if (rst) begin
            if (por) begin
                pullup_n_reg <= `TPG_PULLUP_N_RESET;
            end
        end else begin
            pullup_n_reg <= pullup_n_next;
        end
    end

    // ==========================================================
    // Change flag
    always @(posedge clk) begin
        if (rst) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // ==========================================================
    // Port A read data
    always @(posedge clk) begin
        if (rst) begin
            port_a_data_rdata <= 5'h00;
        end else if (port_a_data_rd) begin
            port_a_data_rdata <= port_a_in;
        end
    end

    // ==========================================================
    // Port B read data
    always @(posedge clk) begin
        if (rst) begin
            port_b_data_rdata <= 8'h00;
        end else if (port_b_data_rd) begin
            port_b_data_rdata <= port_b_in;
        end
    end

    // ==========================================================
    // Port A direction output
    always @(posedge clk) begin
        if (rst) begin
            port_a_direction <= `TPG_A_DIR_RESET;
        end else begin
            port_a_direction <= a_dir_next;
        end
    end

    // ==========================================================
    // Port B direction output
    always @(posedge clk) begin
        if (rst) begin
            port_b_direction <= `TPG_B_DIR_RESET;
        end else begin
            port_b_direction <= b_dir_next;
        end
    end

    // ==========================================================
    // Pull-up control output
    always @(posedge clk) begin
        if (rst) begin
            weak_pullup_disable_n <= `TPG_PULLUP_N_RESET;
        end else begin
            weak_pullup_disable_n <= pullup_n_next;
        end
    end

    // ==========================================================
    // Change flag output
    always @(posedge clk) begin
        if (rst) begin
            port_b_change_flag <= 1'b0;
        end else begin
            port_b_change_flag <= flag_next;
        end
    end

    // ==========================================================
    // Wake request
    always @(posedge clk) begin
        if (rst) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= wake_next;
        end
    end

    // ==========================================================
    // Port A pad drive
    always @(posedge clk) begin
        if (rst) begin
            port_a_out <= `TPG_A_LATCH_RESET;
        end else begin
            port_a_out <= a_out_next;
        end
    end

    // ==========================================================
    // Port A pad enable
    always @(posedge clk) begin
        if (rst) begin
            port_a_oe <= 5'h00;
        end else begin
            port_a_oe <= a_oe_next;
        end
    end

    // ==========================================================
    // Timer clock feed
    always @(posedge clk) begin
        if (rst) begin
            timer_external_clock_in <= 1'b0;
        end else begin
            timer_external_clock_in <= port_a_in[`TPG_A_OPEN_DRAIN_BIT];
        end
    end

    // ==========================================================
    // Port B pad drive
    always @(posedge clk) begin
        if (rst) begin
            port_b_out <= `TPG_B_LATCH_RESET;
        end else begin
            port_b_out <= b_latch_next;
        end
    end

    // ==========================================================
    // Port B pad enable
    always @(posedge clk) begin
        if (rst) begin
            port_b_oe <= 8'h00;
        end else begin
            port_b_oe <= ~b_dir_next;
        end
    end

    // ==========================================================
    // Port B pull-ups
    always @(posedge clk) begin
        if (rst) begin
            port_b_pullup_en <= 8'h00;
        end else begin
            port_b_pullup_en <= b_pullup_next;
        end
    end
endmodule // tpg_gpio

// >>> tb/tpg_pins.sv
module tpg_pins #(parameter int W = 8) (
    // Pad side of the block
    input  logic         clk,
    input  logic [W-1:0] oe, out, pu, drv, val,
    // Resolved pin level
    output logic [W-1:0] pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic flt = 1'h0;
    always @(posedge clk) flt <= ~flt;
    // Driver, then switch, then pull-up, else noise
    assign pin = oe & out | ~oe & drv & val | ~oe & ~drv & (pu | {W{flt}});
endmodule // tpg_pins

// >>> tb/tpg_gpio_asserts.sv
module tpg_gpio_asserts (
    input logic       clk, rst, por, sleep_active, wake_request, timer_external_clock_in,
    input logic       port_b_data_rd, port_b_data_wr, port_b_change_flag_clr, weak_pullup_wr,
    input logic       port_b_change_flag, weak_pullup_disable_n,
    input logic [4:0] port_a_in, port_a_out, port_a_oe, port_a_direction,
    input logic [7:0] port_b_in, port_b_oe, port_b_direction, port_b_pullup_en
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ====================
    // Change detection
    sequence s_chg;
        port_b_data_rd ##1 !port_b_data_rd && !port_b_data_wr &&
            |((port_b_in[7:4] ^ $past(port_b_in[7:4])) & port_b_direction[7:4]);
    endsequence
    sequence s_clr;
        port_b_data_rd ##1 (!port_b_data_rd && $stable(port_b_in[7:4]))[*2]
            ##0 port_b_change_flag_clr;
    endsequence
    a_change_sets: assert property (s_chg |-> ##[1:3] port_b_change_flag)
        else $error("flag not set");
    a_flag_clears: assert property (s_clr |=> !port_b_change_flag)
        else $error("flag not cleared");
    a_sleep_wake: assert property ((sleep_active && port_b_change_flag)[*2] |-> wake_request)
        else $error("no wake");
    // ====================
    // Pins and reset
    a_dir_drive: assert property (
        {port_b_oe, port_a_oe[3:0]} == ~{port_b_direction, port_a_direction[3:0]})
        else $error("enable wrong");
    a_open_drain: assert property (!port_a_out[4] && !(port_a_oe[4] && port_a_direction[4]))
        else $error("bit 4 drive");
    a_timer_feed: assert property (!$past(rst) |->
        timer_external_clock_in == $past(port_a_in[4])) else $error("timer input");
    a_pullup_set: assert property (!$past(rst) |->
        port_b_pullup_en == (port_b_direction & {8{!weak_pullup_disable_n}})) else $error("pull-up");
    a_reset_state: assert property ($past(rst) |-> port_a_direction == 5'h1F &&
        port_b_direction == 8'hFF && (weak_pullup_disable_n || !$past(por))) else $error("reset");
    a_por_pullup: assert property ($past(rst) && $past(por) && !weak_pullup_wr |=>
        weak_pullup_disable_n && port_b_pullup_en == 8'h00) else $error("pull-up after power-on");
endmodule // tpg_gpio_asserts
bind tpg_gpio tpg_gpio_asserts u_chk (.*);

// >>> tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst, por, sleep_active = 0, port_a_data_wr = 0, port_a_data_rd = 0;
    logic port_a_direction_wr = 0, port_b_data_wr = 0, port_b_data_rd = 0, weak_pullup_wr = 0;
    logic port_b_direction_wr = 0, weak_pullup_disable_n_wdata = 0, port_b_change_flag_clr = 0;
    logic weak_pullup_disable_n, port_b_change_flag, wake_request, timer_external_clock_in;
    logic [4:0] port_a_data_wmask = 0, port_a_data_wdata = 0, port_a_direction_wdata = 0;
    logic [4:0] port_a_in, port_a_out, port_a_oe, port_a_data_rdata, port_a_direction, a_val = 0;
    logic [7:0] port_b_data_wmask = 0, port_b_data_wdata = 0, port_b_direction_wdata = 0;
    logic [7:0] port_b_in, port_b_out, port_b_oe, port_b_pullup_en, port_b_data_rdata;
    logic [7:0] port_b_direction, b_drv = 8'hFF, b_val = 0;
    int num_errors = 0, comparisons = 0, cycles = 0;
    tpg_gpio dut (.*);
    tpg_pins #(.W(5)) pa (.clk, .oe(port_a_oe), .out(port_a_out), .pu(5'h00), .drv(5'h1F),
        .val(a_val), .pin(port_a_in));
    tpg_pins pb (.clk, .oe(port_b_oe), .out(port_b_out), .pu(port_b_pullup_en), .drv(b_drv),
        .val(b_val), .pin(port_b_in));
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 400) begin
            num_errors++;
            stop_test;
        end
    end
    task step;
        @(posedge clk);
        {port_a_data_wr, port_a_data_rd, port_a_direction_wr, port_b_data_wr, port_b_data_rd,
            port_b_direction_wr, weak_pullup_wr, port_b_change_flag_clr} <= 0;
        @(negedge clk);
    endtask
    task check(input logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task do_reset(input logic p);
        {rst, por} = {1'h1, p};
        repeat (2) step;
        {rst, por} = 2'h0;
        step;
    endtask
    task t_port_a;
        a_val = 5'h15;
        {port_a_data_wr, port_a_data_rd, port_a_data_wmask} = 7'h61;
        step;
        port_a_direction_wr = 1;
        step;
        port_a_data_rd = 1;
        step;
        check(port_a_out[3:0], 4'h4);
        check(port_a_oe, 5'h0F);
        check(port_a_direction, 5'h00);
        check(port_a_data_rdata, 5'h14);
        check(timer_external_clock_in, 1'h1);
    endtask
    task t_port_b;
        b_drv = 8'hC0;
        {weak_pullup_wr, port_b_direction_wr, port_b_data_wr} = 3'h7;
        {port_b_direction_wdata, port_b_data_wmask, port_b_data_wdata} = 24'hF0FFA5;
        step;
        port_b_data_rd = 1;
        step;
        check(port_b_pullup_en, 8'hF0);
        check(port_b_oe, 8'h0F);
        check(port_b_direction, 8'hF0);
        check(port_b_out, 8'hA5);
        check(port_b_data_rdata, 8'h35);
    endtask
    task t_change;
        sleep_active = 1;
        port_b_data_rd = 1;
        repeat (2) step;
        port_b_change_flag_clr = 1;
        step;
        check(port_b_change_flag, 1'h0);
        port_b_data_rd = 1; // Single read, no polling
        step;
        b_drv = 8'hD0;
        repeat (3) step;
        check(port_b_change_flag, 1'h1);
        check(wake_request, 1'h1);
        port_b_change_flag_clr = 1;
        repeat (2) step;
        check(port_b_change_flag, 1'h1);
        {port_b_direction_wr, port_b_data_rd, port_b_direction_wdata} = 10'h370;
        repeat (2) step;
        port_b_change_flag_clr = 1;
        repeat (2) step;
        check(port_b_change_flag, 1'h0);
    endtask
    initial begin
        do_reset(1);
        check(weak_pullup_disable_n, 1'h1);
        t_port_a;
        t_port_b;
        t_change;
        do_reset(0);
        check({weak_pullup_disable_n, port_a_direction}, 6'h1F);
        stop_test;
    end
endmodule // testbench
